/* File: rtl/stack_cfg_pkg.sv */
// Purpose: Shared constants and decode functions for the stack strap configuration block
// Assumes: Strap pins are digitised elsewhere into ohms to ground and a divider fraction
// Notes:   Thresholds sit midway between neighbouring nominal values
//
// How it works
// - Follower ground codes 10 and 11 give fourth position, 40/52 A or 30/39 A.
// - At power-on the controller queries each follower, which answers its phase position.
// - Any wrong answer sets the power-on fault flag and keeps conversion off.
// - After all answers the controller forwards remaining strap settings; followers adopt them.
// - Ground resistor decodes to a four-bit code, nominal 4640 to 82500 ohms.
// - Divider ratio decodes to its own four-bit code, 0 to 15.
// - Multi-byte settings go byte 0 first (bits 7:0), then ascending bytes.
// - A follower uses only its follower strap and ignores every other strap.
// - The controller always holds position zero; followers count from one.
package stack_cfg_pkg;

    localparam int OHMS_W    = 17;
    localparam int FRAC_W    = 8;
    localparam int CODE_W    = 4;
    localparam int POS_W     = 2;
    localparam int PH_W      = 3;
    localparam int LIM_W     = 8;
    localparam int SET_W     = 16;
    localparam int SET_BYTES = 2;
    localparam int N_THRESH  = 15;

    localparam logic [OHMS_W-1:0] GND_NOM_MIN_OHMS = 17'h01220;
    localparam logic [OHMS_W-1:0] GND_NOM_MAX_OHMS = 17'h14244;
    localparam logic [FRAC_W-1:0] DIV_TOP_FRAC     = 8'he7;

    localparam logic [OHMS_W-1:0] GND_THRESH [0:N_THRESH-1] = '{
        17'h0140a, 17'h01847, 17'h01d6a, 17'h023a5, 17'h02b2a, 17'h03458, 17'h03f7a, 17'h04cc2,
        17'h05cf8, 17'h070b2, 17'h08886, 17'h0a56e, 17'h0c864, 17'h0f2c6, 17'h12624};
    localparam logic [FRAC_W-1:0] DIV_THRESH [0:N_THRESH-1] = '{
        8'h34, 8'h42, 8'h50, 8'h5d, 8'h6c, 8'h7a, 8'h86, 8'h92,
        8'h9e, 8'hab, 8'hb8, 8'hc3, 8'hce, 8'hd9, 8'he2};

    localparam logic [LIM_W-1:0] WARN_HI_A  = 8'h28;
    localparam logic [LIM_W-1:0] FAULT_HI_A = 8'h34;
    localparam logic [LIM_W-1:0] WARN_LO_A  = 8'h1e;
    localparam logic [LIM_W-1:0] FAULT_LO_A = 8'h27;

    localparam logic [POS_W-1:0] CTRL_POSITION = 2'h0;
    localparam logic [PH_W-1:0]  SOLO_PHASES   = 3'h1;

    localparam int CLK_PERIOD_NS      = 5;
    localparam int ANSWER_TIMEOUT_NS  = 10000;
    localparam int ANSWER_TIMEOUT_CYC = ANSWER_TIMEOUT_NS / CLK_PERIOD_NS;
    localparam int TIMER_W            = 11;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_QUERY  = 3'h1,
        ST_WAIT   = 3'h2,
        ST_SEND   = 3'h3,
        ST_FOLLOW = 3'h4,
        ST_RUN    = 3'h5,
        ST_FAULT  = 3'h6
    } cfg_state_t;

    function automatic logic [CODE_W-1:0] count_hits(input logic [N_THRESH-1:0] hits);
        logic [CODE_W-1:0] n;
        n = 4'h0;
        for (int i = 0; i < N_THRESH; i++) begin
            n = n + {3'h0, hits[i]};
        end
        return n;
    endfunction : count_hits

    // Result is {valid, position, phases, low_limits}; odd valid codes select the low limit pair
    function automatic logic [6:0] follower_decode(input logic [CODE_W-1:0] code);
        logic [6:0] r;
        r = 7'h00;
        case (code)
            4'h6, 4'h7: r = {1'b1, 2'h1, 3'h2, code[0]};
            4'h4, 4'h5: r = {1'b1, 2'h1, 3'h3, code[0]};
            4'h8, 4'h9: r = {1'b1, 2'h2, 3'h3, code[0]};
            4'h2, 4'h3: r = {1'b1, 2'h1, 3'h4, code[0]};
            4'he, 4'hf: r = {1'b1, 2'h2, 3'h4, code[0]};
            4'ha, 4'hb: r = {1'b1, 2'h3, 3'h4, code[0]};
            default:    r = 7'h00;
        endcase
        return r;
    endfunction : follower_decode

endpackage : stack_cfg_pkg

/* File: rtl/stack_pinstrap_config.sv */
// Purpose: Power-on stack configuration for controller and follower roles
// Assumes: Follower link peers run on clk_i; role pin is asynchronous
// Notes:   Fault is sticky until reset; a missing answer counts as a mismatch
`timescale 1ns/10ps
module stack_pinstrap_config (
    input  wire logic                               clk_i,
    input  wire logic                               rst_n_i,
    input  wire logic                               follower_mode_i,
    input  wire logic                               strap_valid_i,
    input  wire logic [stack_cfg_pkg::OHMS_W-1:0]   follower_strap_ohms_i,
    input  wire logic [stack_cfg_pkg::FRAC_W-1:0]   follower_strap_frac_i,
    input  wire logic [stack_cfg_pkg::OHMS_W-1:0]   aux_strap_ohms_i,
    input  wire logic [stack_cfg_pkg::FRAC_W-1:0]   aux_strap_frac_i,
    output logic                                    query_valid_o,
    output logic      [stack_cfg_pkg::POS_W-1:0]    query_index_o,
    input  wire logic                               answer_valid_i,
    input  wire logic [stack_cfg_pkg::POS_W-1:0]    answer_position_i,
    input  wire logic [stack_cfg_pkg::PH_W-1:0]     answer_phases_i,
    output logic                                    cfg_valid_o,
    output logic      [7:0]                         cfg_data_o,
    input  wire logic                               query_valid_i,
    input  wire logic [stack_cfg_pkg::POS_W-1:0]    query_index_i,
    output logic                                    answer_valid_o,
    output logic      [stack_cfg_pkg::POS_W-1:0]    answer_position_o,
    output logic      [stack_cfg_pkg::PH_W-1:0]     answer_phases_o,
    input  wire logic                               cfg_valid_i,
    input  wire logic [7:0]                         cfg_data_i,
    output logic      [stack_cfg_pkg::POS_W-1:0]    position_o,
    output logic      [stack_cfg_pkg::PH_W-1:0]     phases_o,
    output logic      [stack_cfg_pkg::LIM_W-1:0]    warn_limit_o,
    output logic      [stack_cfg_pkg::LIM_W-1:0]    fault_limit_o,
    output logic      [stack_cfg_pkg::SET_W-1:0]    settings_o,
    output logic                                    por_fault_o,
    output logic                                    conv_enable_o
);
    logic                               role_meta_ff;
    logic                               follower_ff;
    stack_cfg_pkg::cfg_state_t          state_ff;
    stack_cfg_pkg::cfg_state_t          nxt_state;
    logic [stack_cfg_pkg::POS_W-1:0]    idx_ff;
    logic [stack_cfg_pkg::TIMER_W-1:0]  timer_ff;
    logic                               byte_ff;
    logic [stack_cfg_pkg::CODE_W-1:0]   gnd_code_ff;

    wire logic [stack_cfg_pkg::CODE_W-1:0] flw_gnd;
    wire logic [stack_cfg_pkg::CODE_W-1:0] flw_div;
    wire logic [stack_cfg_pkg::CODE_W-1:0] aux_gnd;
    wire logic [stack_cfg_pkg::CODE_W-1:0] aux_div;
    wire logic [6:0]                       dec;
    wire logic                             dec_ok;
    wire logic [stack_cfg_pkg::PH_W-1:0]   dec_phases;
    wire logic                             mismatch;
    wire logic                             timeout;
    wire logic                             last_idx;
    wire logic                             last_byte;
    wire logic [7:0]                       send_byte;
    wire logic                             my_query;

    strap_code_decoder u_flw_dec (
        .gnd_ohms_i (follower_strap_ohms_i),
        .div_frac_i (follower_strap_frac_i),
        .gnd_code_o (flw_gnd),
        .div_code_o (flw_div)
    );

    strap_code_decoder u_aux_dec (
        .gnd_ohms_i (aux_strap_ohms_i),
        .div_frac_i (aux_strap_frac_i),
        .gnd_code_o (aux_gnd),
        .div_code_o (aux_div)
    );

    assign dec        = stack_cfg_pkg::follower_decode(flw_gnd);
    assign dec_ok     = dec[6];
    // An unusable stack code on the controller means it runs alone
    assign dec_phases = dec_ok ? dec[3:1] : stack_cfg_pkg::SOLO_PHASES;
    assign mismatch   = (answer_position_i != idx_ff) || (answer_phases_i != phases_o);
    assign timeout    = timer_ff == stack_cfg_pkg::TIMER_W'(stack_cfg_pkg::ANSWER_TIMEOUT_CYC - 1);
    assign last_idx   = {1'b0, idx_ff} == phases_o - 3'h1;
    assign last_byte  = byte_ff == 1'(stack_cfg_pkg::SET_BYTES - 1);
    assign send_byte  = settings_o[{byte_ff, 3'h0} +: 8];
    assign my_query   = follower_ff && query_valid_i && (query_index_i == position_o)
                        && ((state_ff == stack_cfg_pkg::ST_FOLLOW) || (state_ff == stack_cfg_pkg::ST_RUN));

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            stack_cfg_pkg::ST_IDLE: begin
                if (strap_valid_i) begin
                    if (follower_ff) begin
                        nxt_state = dec_ok ? stack_cfg_pkg::ST_FOLLOW : stack_cfg_pkg::ST_FAULT;
                    end else if (dec_phases > stack_cfg_pkg::SOLO_PHASES) begin
                        nxt_state = stack_cfg_pkg::ST_QUERY;
                    end else begin
                        nxt_state = stack_cfg_pkg::ST_RUN;
                    end
                end
            end
            stack_cfg_pkg::ST_QUERY: nxt_state = stack_cfg_pkg::ST_WAIT;
            stack_cfg_pkg::ST_WAIT: begin
                if (answer_valid_i && mismatch) begin
                    nxt_state = stack_cfg_pkg::ST_FAULT;
                end else if (answer_valid_i) begin
                    nxt_state = last_idx ? stack_cfg_pkg::ST_SEND : stack_cfg_pkg::ST_QUERY;
                end else if (timeout) begin
                    nxt_state = stack_cfg_pkg::ST_FAULT;
                end
            end
            stack_cfg_pkg::ST_SEND: begin
                if (last_byte) begin
                    nxt_state = stack_cfg_pkg::ST_RUN;
                end
            end
            stack_cfg_pkg::ST_FOLLOW: begin
                if (cfg_valid_i && last_byte) begin
                    nxt_state = stack_cfg_pkg::ST_RUN;
                end
            end
            stack_cfg_pkg::ST_RUN:   nxt_state = stack_cfg_pkg::ST_RUN;
            stack_cfg_pkg::ST_FAULT: nxt_state = stack_cfg_pkg::ST_FAULT;
            default:                 nxt_state = stack_cfg_pkg::ST_FAULT;
        endcase
    end

    // Role pin is a strap from outside, so it is resynchronised before use
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            role_meta_ff <= 1'b0;
            follower_ff  <= 1'b0;
        end else begin
            role_meta_ff <= follower_mode_i;
            follower_ff  <= role_meta_ff;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_ff      <= stack_cfg_pkg::ST_IDLE;
            por_fault_o   <= 1'b0;
            conv_enable_o <= 1'b0;
        end else begin
            state_ff      <= nxt_state;
            por_fault_o   <= nxt_state == stack_cfg_pkg::ST_FAULT;
            conv_enable_o <= nxt_state == stack_cfg_pkg::ST_RUN;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            gnd_code_ff   <= 4'h0;
            position_o    <= stack_cfg_pkg::CTRL_POSITION;
            phases_o      <= stack_cfg_pkg::SOLO_PHASES;
            warn_limit_o  <= stack_cfg_pkg::WARN_HI_A;
            fault_limit_o <= stack_cfg_pkg::FAULT_HI_A;
        end else if (state_ff == stack_cfg_pkg::ST_IDLE && strap_valid_i) begin
            gnd_code_ff   <= flw_gnd;
            position_o    <= follower_ff ? dec[5:4] : stack_cfg_pkg::CTRL_POSITION;
            phases_o      <= dec_phases;
            warn_limit_o  <= dec[0] ? stack_cfg_pkg::WARN_LO_A : stack_cfg_pkg::WARN_HI_A;
            fault_limit_o <= dec[0] ? stack_cfg_pkg::FAULT_LO_A : stack_cfg_pkg::FAULT_HI_A;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            settings_o <= 16'h0000;
        end else if (state_ff == stack_cfg_pkg::ST_IDLE && strap_valid_i) begin
            // Followers drop their own aux strap and wait for the controller's copy
            settings_o <= follower_ff ? 16'h0000 : {aux_div, aux_gnd, flw_div, flw_gnd};
        end else if (state_ff == stack_cfg_pkg::ST_FOLLOW && cfg_valid_i) begin
            settings_o[{byte_ff, 3'h0} +: 8] <= cfg_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            idx_ff   <= 2'h1;
            timer_ff <= '0;
            byte_ff  <= 1'b0;
        end else begin
            if (state_ff == stack_cfg_pkg::ST_WAIT && answer_valid_i) begin
                idx_ff <= idx_ff + 2'h1;
            end
            timer_ff <= (state_ff == stack_cfg_pkg::ST_WAIT) ? timer_ff + 1'b1 : '0;
            if (state_ff == stack_cfg_pkg::ST_SEND
                || (state_ff == stack_cfg_pkg::ST_FOLLOW && cfg_valid_i)) begin
                byte_ff <= byte_ff + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            query_valid_o     <= 1'b0;
            query_index_o     <= 2'h0;
            cfg_valid_o       <= 1'b0;
            cfg_data_o        <= 8'h00;
            answer_valid_o    <= 1'b0;
            answer_position_o <= 2'h0;
            answer_phases_o   <= 3'h0;
        end else begin
            query_valid_o     <= state_ff == stack_cfg_pkg::ST_QUERY;
            query_index_o     <= idx_ff;
            cfg_valid_o       <= state_ff == stack_cfg_pkg::ST_SEND;
            cfg_data_o        <= send_byte;
            answer_valid_o    <= my_query;
            answer_position_o <= position_o;
            answer_phases_o   <= phases_o;
        end
    end

    sequence first_byte_s;
        cfg_valid_o && cfg_data_o == settings_o[7:0];
    endsequence

    sequence second_byte_s;
        cfg_valid_o && cfg_data_o == settings_o[15:8];
    endsequence

    follower_limits_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        follower_ff && state_ff == stack_cfg_pkg::ST_RUN && gnd_code_ff[3:1] == 3'h5
        |-> position_o == 2'h3 && phases_o == 3'h4
            && warn_limit_o == (gnd_code_ff[0] ? 8'h1e : 8'h28)
            && fault_limit_o == (gnd_code_ff[0] ? 8'h27 : 8'h34))
        else $error("follower code 10/11 decoded wrongly");

    follower_answer_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        my_query |=> answer_valid_o && answer_position_o == position_o && answer_phases_o == phases_o)
        else $error("follower failed to answer its query");

    mismatch_fault_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        state_ff == stack_cfg_pkg::ST_WAIT && answer_valid_i && mismatch
        |=> por_fault_o && !conv_enable_o ##1 por_fault_o && !conv_enable_o)
        else $error("mismatch did not raise fault");

    byte_order_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(cfg_valid_o) |-> first_byte_s ##1 second_byte_s)
        else $error("settings bytes out of order");

    follower_adopt_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        state_ff == stack_cfg_pkg::ST_FOLLOW && cfg_valid_i && byte_ff
        |=> settings_o[15:8] == $past(cfg_data_i) && conv_enable_o)
        else $error("follower did not adopt settings");

    gnd_range_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (follower_strap_ohms_i <= stack_cfg_pkg::GND_NOM_MIN_OHMS |-> flw_gnd == 4'h0)
        and (follower_strap_ohms_i >= stack_cfg_pkg::GND_NOM_MAX_OHMS |-> flw_gnd == 4'hf))
        else $error("ground code out of range");

    div_top_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        follower_strap_frac_i >= stack_cfg_pkg::DIV_TOP_FRAC |-> flw_div == 4'hf)
        else $error("divider code top decode wrong");

    aux_ignored_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        follower_ff && $past(follower_ff) && state_ff == stack_cfg_pkg::ST_FOLLOW
        && $past(state_ff) == stack_cfg_pkg::ST_IDLE |-> settings_o == 16'h0000)
        else $error("follower took aux strap");

    ctrl_position_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !follower_ff && !$past(follower_ff) && state_ff != stack_cfg_pkg::ST_IDLE |-> position_o == 2'h0)
        else $error("controller not at position zero");

    enable_gate_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(conv_enable_o) |-> $past(state_ff) == stack_cfg_pkg::ST_SEND
            || $past(state_ff) == stack_cfg_pkg::ST_FOLLOW
            || ($past(state_ff) == stack_cfg_pkg::ST_IDLE && phases_o == stack_cfg_pkg::SOLO_PHASES))
        else $error("conversion enabled early");
endmodule : stack_pinstrap_config

/* File: rtl/strap_code_decoder.sv */
// Purpose: Turn one digitised strap pin into its ground code and divider code
// Assumes: Inputs come from logic on the same clock
// Notes:   Purely combinational; the caller latches the codes
`timescale 1ns/10ps
module strap_code_decoder (
    input  wire logic [stack_cfg_pkg::OHMS_W-1:0] gnd_ohms_i,
    input  wire logic [stack_cfg_pkg::FRAC_W-1:0] div_frac_i,
    output wire logic [stack_cfg_pkg::CODE_W-1:0] gnd_code_o,
    output wire logic [stack_cfg_pkg::CODE_W-1:0] div_code_o
);
    wire logic [stack_cfg_pkg::N_THRESH-1:0] gnd_hits;
    wire logic [stack_cfg_pkg::N_THRESH-1:0] div_hits;

    genvar g;
    generate
        for (g = 0; g < stack_cfg_pkg::N_THRESH; g++) begin : g_cmp
            assign gnd_hits[g] = gnd_ohms_i >= stack_cfg_pkg::GND_THRESH[g];
            assign div_hits[g] = div_frac_i >= stack_cfg_pkg::DIV_THRESH[g];
        end
    endgenerate

    // Thermometer count keeps the code monotonic even if the table shifts
    assign gnd_code_o = stack_cfg_pkg::count_hits(gnd_hits);
    assign div_code_o = stack_cfg_pkg::count_hits(div_hits);
endmodule : strap_code_decoder

/* File: tb/stack_follower_model.sv */
// Purpose: Behavioural loop follower that answers phase queries from the controller
// Assumes: Answer delay of at least one cycle; one query outstanding at a time
// Notes:   bad_i corrupts the phases field so the controller sees a mismatch
`timescale 1ns/10ps
module stack_follower_model (
    input  wire logic                            clk_i,
    input  wire logic                            query_valid_i,
    input  wire logic [stack_cfg_pkg::POS_W-1:0] query_index_i,
    input  wire logic [stack_cfg_pkg::PH_W-1:0]  phases_i,
    input  wire logic [15:0]                     delay_i,
    input  wire logic                            bad_i,
    output logic                                 answer_valid_o,
    output logic      [stack_cfg_pkg::POS_W-1:0] answer_position_o,
    output logic      [stack_cfg_pkg::PH_W-1:0]  answer_phases_o
);
    logic [stack_cfg_pkg::POS_W-1:0] idx;
    logic [stack_cfg_pkg::PH_W-1:0]  ph;
    initial begin
        answer_valid_o    = 1'b0;
        answer_position_o = 2'h0;
        answer_phases_o   = 3'h0;
    end
    always @(posedge clk_i) begin
        if (query_valid_i) begin
            idx = query_index_i;
            ph  = bad_i ? ~phases_i : phases_i;
            repeat (delay_i) @(posedge clk_i);
            answer_valid_o    <= 1'b1;
            answer_position_o <= idx;
            answer_phases_o   <= ph;
            @(posedge clk_i);
            answer_valid_o    <= 1'b0;
            // Released lines must not keep the answer, or a late sample would pass
            answer_position_o <= ~idx;
            answer_phases_o   <= ~ph;
        end
    end
endmodule : stack_follower_model

/* File: tb/stack_pinstrap_config_bench.sv */
// Purpose: Self-checking bench for controller and follower stack configuration
// Assumes: Strap inputs given as ohms and divider fraction; 200 MHz clock
// Notes:   Controller runs against the behavioural follower, prompt and slow
`timescale 1ns/10ps
module stack_pinstrap_config_bench;
    logic        clk_i = 1'b0, rst_n_i = 1'b0, follower_mode_i = 1'b0, strap_valid_i = 1'b0;
    logic [16:0] f_ohms = 17'h0, a_ohms = 17'h01220;
    logic [7:0]  f_frac = 8'h0, a_frac = 8'hf0, cfg_data_i = 8'h0, cfg_data_o;
    logic        query_valid_o, answer_valid_i, cfg_valid_o, query_valid_i = 1'b0, answer_valid_o;
    logic        cfg_valid_i = 1'b0, por_fault_o, conv_enable_o, bad = 1'b0;
    logic [1:0]  query_index_o, answer_position_i, query_index_i = 2'h0, answer_position_o, position_o;
    logic [2:0]  answer_phases_i, answer_phases_o, phases_o;
    logic [7:0]  warn_limit_o, fault_limit_o;
    logic [15:0] settings_o, dly = 16'h1;
    int          n_mismatch = 0, num_checks = 0;

    always #2.5 clk_i = ~clk_i;

    stack_pinstrap_config dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .follower_mode_i(follower_mode_i),
        .strap_valid_i(strap_valid_i), .follower_strap_ohms_i(f_ohms), .follower_strap_frac_i(f_frac),
        .aux_strap_ohms_i(a_ohms), .aux_strap_frac_i(a_frac), .query_valid_o(query_valid_o),
        .query_index_o(query_index_o), .answer_valid_i(answer_valid_i),
        .answer_position_i(answer_position_i), .answer_phases_i(answer_phases_i),
        .cfg_valid_o(cfg_valid_o), .cfg_data_o(cfg_data_o), .query_valid_i(query_valid_i),
        .query_index_i(query_index_i), .answer_valid_o(answer_valid_o),
        .answer_position_o(answer_position_o), .answer_phases_o(answer_phases_o),
        .cfg_valid_i(cfg_valid_i), .cfg_data_i(cfg_data_i), .position_o(position_o),
        .phases_o(phases_o), .warn_limit_o(warn_limit_o), .fault_limit_o(fault_limit_o),
        .settings_o(settings_o), .por_fault_o(por_fault_o), .conv_enable_o(conv_enable_o));

    stack_follower_model peer (.clk_i(clk_i), .query_valid_i(query_valid_o), .query_index_i(query_index_o),
        .phases_i(3'h4), .delay_i(dly), .bad_i(bad), .answer_valid_o(answer_valid_i),
        .answer_position_o(answer_position_i), .answer_phases_o(answer_phases_i));

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : complete_run

    task automatic expect_eq(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : expect_eq

    task automatic start_up(input logic fmode, input logic [16:0] ohms);
        @(posedge clk_i);
        rst_n_i         <= 1'b0;
        strap_valid_i   <= 1'b0;
        follower_mode_i <= fmode;
        f_ohms          <= ohms;
        f_frac          <= 8'h70;
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        strap_valid_i <= 1'b1;
    endtask : start_up

    // Code 10 ground strap, divider code 5: a four-phase stack; aux strap is code 0 / 15
    task automatic ctrl_case(input logic [15:0] delay, input logic corrupt);
        logic [1:0] idx_q[$];
        logic [7:0] byte_q[$];
        int         tail;
        int         n;
        dly  <= delay;
        bad  <= corrupt;
        tail = -1;
        start_up(1'b0, 17'h07b70);
        for (n = 0; n < 6000 && tail != 0; n++) begin
            @(posedge clk_i);
            #1;
            if (query_valid_o === 1'b1) begin
                idx_q.push_back(query_index_o);
                expect_eq(conv_enable_o, 16'h0);
            end
            if (cfg_valid_o === 1'b1) byte_q.push_back(cfg_data_o);
            if (tail > 0) tail--;
            else if (tail < 0 && (por_fault_o === 1'b1 || byte_q.size() == 2)) tail = 4;
        end
        if (tail != 0) begin
            n_mismatch++;
            complete_run();
        end
        // A silent follower past the answer limit is treated like a wrong answer
        if (!corrupt && delay < stack_cfg_pkg::ANSWER_TIMEOUT_CYC) begin
            expect_eq(idx_q.size(), 16'h3);
            foreach (idx_q[i]) expect_eq(idx_q[i], i + 1);
            expect_eq(byte_q.size(), 16'h2);
            if (byte_q.size() == 2) expect_eq({byte_q[1], byte_q[0]}, 16'hf05a);
            expect_eq({position_o, phases_o}, 16'h04);
            expect_eq({por_fault_o, conv_enable_o}, 16'h1);
        end else begin
            expect_eq({por_fault_o, conv_enable_o}, 16'h2);
            expect_eq(idx_q.size(), 16'h1);
            expect_eq(byte_q.size(), 16'h0);
        end
        $display("controller test done, delay %0d corrupt %0d", delay, corrupt);
    endtask : ctrl_case

    task automatic ask(input logic [1:0] idx, output logic seen, output logic [4:0] ans);
        @(posedge clk_i);
        query_valid_i <= 1'b1;
        query_index_i <= idx;
        seen = 1'b0;
        ans  = 5'h0;
        // The answer stands for one cycle only, right after the query edge
        repeat (3) begin
            @(posedge clk_i);
            query_valid_i <= 1'b0;
            query_index_i <= ~idx;
            #1;
            if (answer_valid_o === 1'b1) begin
                seen = 1'b1;
                ans  = {answer_position_o, answer_phases_o};
            end
        end
    endtask : ask

    task automatic send_byte(input logic [7:0] b);
        @(posedge clk_i);
        cfg_valid_i <= 1'b1;
        cfg_data_i  <= b;
        @(posedge clk_i);
        cfg_valid_i <= 1'b0;
        cfg_data_i  <= ~b;
        repeat (3) @(posedge clk_i);
        #1;
    endtask : send_byte

    task automatic follower_case(input logic [16:0] ohms, input logic [7:0] warn, input logic [7:0] fault);
        logic       seen;
        logic [4:0] ans;
        start_up(1'b1, ohms);
        repeat (3) @(posedge clk_i);
        #1;
        expect_eq({position_o, phases_o}, 16'h1c);
        expect_eq({warn_limit_o, fault_limit_o}, {warn, fault});
        expect_eq(settings_o, 16'h0);
        ask(2'h2, seen, ans);
        expect_eq(seen, 16'h0);
        ask(2'h3, seen, ans);
        expect_eq({seen, ans}, 16'h3c);
        send_byte(8'h12);
        expect_eq({conv_enable_o, settings_o[7:0]}, 16'h012);
        send_byte(8'h34);
        expect_eq(settings_o, 16'h3412);
        expect_eq({por_fault_o, conv_enable_o}, 16'h1);
        $display("follower test done, warn %h fault %h", warn, fault);
    endtask : follower_case

    // Ground code 0 is no stack code: a follower must fault, a controller runs alone
    task automatic strap_fault_case();
        start_up(1'b1, 17'h00000);
        repeat (3) @(posedge clk_i);
        #1;
        expect_eq({por_fault_o, conv_enable_o}, 16'h2);
        start_up(1'b0, 17'h00000);
        repeat (3) @(posedge clk_i);
        #1;
        expect_eq({query_valid_o, por_fault_o, conv_enable_o}, 16'h1);
        expect_eq({position_o, phases_o}, 16'h01);
        $display("strap fault test done");
    endtask : strap_fault_case

    initial begin
        follower_case(17'h07b70, 8'h28, 8'h34);
        follower_case(17'h0959c, 8'h1e, 8'h27);
        ctrl_case(16'h1, 1'b0);
        ctrl_case(16'd300, 1'b0);
        ctrl_case(16'h1, 1'b1);
        ctrl_case(16'd2100, 1'b0);
        strap_fault_case();
        complete_run();
    end
endmodule : stack_pinstrap_config_bench
